// ==== rtl/hmb_map.vh ====
// Constants for the host memory buffer configuration block
`ifndef HMB_MAP_VH
`define HMB_MAP_VH
`define HMB_ENTRY_BYTES     64'h0000000000000010
`define HMB_ADDR_LOW_MASK   32'hfffffff0
`define HMB_FLAG_ENABLE     0
`define HMB_FLAG_RETURN     1
`define HMB_CNT_MSB         95
`define HMB_CNT_LSB         64
`define HMB_ATTR_WORDS      10'h3ff
`define HMB_ATTR_IDX_SIZE   10'h000
`define HMB_ATTR_IDX_LOW    10'h001
`define HMB_ATTR_IDX_HIGH   10'h002
`define HMB_ATTR_IDX_COUNT  10'h003
`endif

// ==== rtl/hmb_fetch.v ====
// Descriptor list walker for the host memory buffer
`timescale 1ns/1ns
`include "hmb_map.vh"
module hmb_fetch (
  // Clock and reset
  input  wire         i_sys_clk,
  input  wire         i_rst,
  // Control
  input  wire         i_start,
  input  wire         i_enable,
  input  wire [63:0]  i_list_base,
  input  wire [31:0]  i_entry_count,
  // Memory read port
  output reg          o_rd_req,
  output reg  [63:0]  o_rd_addr,
  input  wire         i_rd_valid,
  input  wire [127:0] i_rd_data,
  // Results
  output reg          o_entry_valid,
  output reg  [63:0]  o_entry_page_address,
  output reg  [31:0]  o_entry_page_count,
  output reg          o_busy,
  output reg          o_done,
  output reg  [31:0]  o_fetched
);
  localparam ST_IDLE = 2'd0;
  localparam ST_REQ  = 2'd1;
  localparam ST_WAIT = 2'd2;
  reg [1:0]  state_reg;
  reg [31:0] left_reg;
  // Walk the list one entry at a time; a disable aborts the walk at once
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg            <= ST_IDLE;
      left_reg             <= 32'h00000000;
      o_rd_req             <= 1'b0;
      o_rd_addr            <= 64'h0000000000000000;
      o_entry_valid        <= 1'b0;
      o_entry_page_address <= 64'h0000000000000000;
      o_entry_page_count   <= 32'h00000000;
      o_busy               <= 1'b0;
      o_done               <= 1'b0;
      o_fetched            <= 32'h00000000;
    end else begin
      o_entry_valid <= 1'b0;
      o_done        <= 1'b0;
      o_rd_req      <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (i_start && i_enable) begin
            o_rd_addr <= i_list_base;
            left_reg  <= i_entry_count;
            o_fetched <= 32'h00000000;
            if (i_entry_count == 32'h00000000) begin
              o_done <= 1'b1;
            end else begin
              o_busy    <= 1'b1;
              state_reg <= ST_REQ;
            end
          end
        end
        ST_REQ: begin
          if (!i_enable) begin
            o_busy    <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            o_rd_req  <= 1'b1;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!i_enable) begin
            o_busy    <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (i_rd_valid) begin
            // Reserved top dword of the entry is dropped
            o_entry_valid        <= 1'b1;
            o_entry_page_address <= i_rd_data[63:0];
            o_entry_page_count   <= i_rd_data[`HMB_CNT_MSB:`HMB_CNT_LSB];
            o_fetched            <= o_fetched + 32'h00000001;
            o_rd_addr            <= o_rd_addr + `HMB_ENTRY_BYTES;
            left_reg             <= left_reg - 32'h00000001;
            if (left_reg == 32'h00000001) begin
              o_busy    <= 1'b0;
              o_done    <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_REQ;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // hmb_fetch

// ==== rtl/hmb_config.v ====
// Host memory buffer set and get feature handling
`timescale 1ns/1ns
`include "hmb_map.vh"
module hmb_config (
  // Clock and reset
  input  wire         i_sys_clk,
  input  wire         i_rst,
  // Set feature command
  input  wire         i_set_valid,
  input  wire [31:0]  i_cdw11,
  input  wire [31:0]  i_cdw12,
  input  wire [31:0]  i_cdw13,
  input  wire [31:0]  i_cdw14,
  input  wire [31:0]  i_cdw15,
  // Get feature command
  input  wire         i_get_valid,
  output reg          o_get_done,
  output reg  [31:0]  o_cpl_dw0,
  output reg          o_attr_wr,
  output reg  [9:0]   o_attr_idx,
  output reg  [31:0]  o_attr_data,
  // Descriptor memory read port
  output reg          o_rd_req,
  output reg  [63:0]  o_rd_addr,
  input  wire         i_rd_valid,
  input  wire [127:0] i_rd_data,
  // Fetched entries and status
  output reg          o_entry_valid,
  output reg  [63:0]  o_entry_page_address,
  output reg  [31:0]  o_entry_page_count,
  output reg          o_buffer_enable_flag,
  output reg          o_buffer_return_flag,
  output reg  [31:0]  o_buffer_pages,
  output reg          o_fetch_busy,
  output reg          o_fetch_done
);
  reg         ret_reg;
  reg  [31:0] size_reg;
  reg  [31:0] low_reg;
  reg  [31:0] high_reg;
  reg  [31:0] count_reg;
  reg  [31:0] valid_reg;
  reg         start_reg;
  reg         attr_run_reg;
  wire        f_rd_req;
  wire [63:0] f_rd_addr;
  wire        f_entry_valid;
  wire [63:0] f_entry_addr;
  wire [31:0] f_entry_cnt;
  wire        f_busy;
  wire        f_done;
  wire [31:0] f_fetched;
  // Retain the last accepted configuration; walk starts a cycle later
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_buffer_enable_flag <= 1'b0;
      ret_reg              <= 1'b0;
      size_reg             <= 32'h00000000;
      low_reg              <= 32'h00000000;
      high_reg             <= 32'h00000000;
      count_reg            <= 32'h00000000;
      start_reg            <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (i_set_valid) begin
        o_buffer_enable_flag <= i_cdw11[`HMB_FLAG_ENABLE];
        ret_reg              <= i_cdw11[`HMB_FLAG_RETURN];
        // Size stays in page units; no byte scaling
        size_reg  <= i_cdw12;
        low_reg   <= i_cdw13 & `HMB_ADDR_LOW_MASK;
        high_reg  <= i_cdw14;
        count_reg <= i_cdw15;
        start_reg <= i_cdw11[`HMB_FLAG_ENABLE];
      end
    end
  end
  // Valid entry count: cleared on a new set, follows completed fetches
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      valid_reg <= 32'h00000000;
    end else if (i_set_valid) begin
      valid_reg <= 32'h00000000;
    end else if (f_entry_valid) begin
      valid_reg <= f_fetched;
    end
  end
  // Reply: dword 0 at once, then four attribute words and the reserved rest zero
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_get_done   <= 1'b0;
      o_cpl_dw0    <= 32'h00000000;
      o_attr_wr    <= 1'b0;
      o_attr_idx   <= 10'h000;
      o_attr_data  <= 32'h00000000;
      attr_run_reg <= 1'b0;
    end else begin
      o_get_done <= 1'b0;
      o_attr_wr  <= 1'b0;
      if (i_get_valid && !attr_run_reg) begin
        o_cpl_dw0 <= {30'h00000000, ret_reg, o_buffer_enable_flag};
        attr_run_reg <= 1'b1;
        o_attr_idx   <= 10'h3ff; // Wraps to word 0 on the first write
      end else if (attr_run_reg) begin
        o_attr_wr  <= 1'b1;
        o_attr_idx <= o_attr_idx + 10'h001;
        case (o_attr_idx + 10'h001)
          `HMB_ATTR_IDX_SIZE:  o_attr_data <= size_reg;
          `HMB_ATTR_IDX_LOW:   o_attr_data <= low_reg & `HMB_ADDR_LOW_MASK;
          `HMB_ATTR_IDX_HIGH:  o_attr_data <= high_reg & `HMB_ADDR_LOW_MASK;
          `HMB_ATTR_IDX_COUNT: o_attr_data <= valid_reg;
          default:             o_attr_data <= 32'h00000000;
        endcase
        if (o_attr_idx + 10'h001 == `HMB_ATTR_WORDS) begin
          attr_run_reg <= 1'b0;
          o_get_done   <= 1'b1;
        end
      end
    end
  end
  // Register the walker results so every output leaves a flop
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rd_req             <= 1'b0;
      o_rd_addr            <= 64'h0000000000000000;
      o_entry_valid        <= 1'b0;
      o_entry_page_address <= 64'h0000000000000000;
      o_entry_page_count   <= 32'h00000000;
      o_buffer_return_flag <= 1'b0;
      o_buffer_pages       <= 32'h00000000;
      o_fetch_busy         <= 1'b0;
      o_fetch_done         <= 1'b0;
    end else begin
      // The walker sees a disable one edge late, so block a read it issued as the flag fell
      o_rd_req             <= f_rd_req & o_buffer_enable_flag;
      o_rd_addr            <= f_rd_addr;
      o_entry_valid        <= f_entry_valid;
      o_entry_page_address <= f_entry_addr;
      o_entry_page_count   <= f_entry_cnt;
      o_buffer_return_flag <= ret_reg;
      o_buffer_pages       <= size_reg;
      o_fetch_busy         <= f_busy;
      o_fetch_done         <= f_done;
    end
  end
  hmb_fetch u_fetch (
    .i_sys_clk            (i_sys_clk),
    .i_rst                (i_rst),
    .i_start              (start_reg),
    .i_enable             (o_buffer_enable_flag),
    .i_list_base          ({high_reg, low_reg}),
    .i_entry_count        (count_reg),
    .o_rd_req             (f_rd_req),
    .o_rd_addr            (f_rd_addr),
    .i_rd_valid           (i_rd_valid),
    .i_rd_data            (i_rd_data),
    .o_entry_valid        (f_entry_valid),
    .o_entry_page_address (f_entry_addr),
    .o_entry_page_count   (f_entry_cnt),
    .o_busy               (f_busy),
    .o_done               (f_done),
    .o_fetched            (f_fetched)
  );
endmodule // hmb_config

// ==== verif/hmb_config_sva.sv ====
// Concurrent checks on the configuration block ports
`timescale 1ns/1ns
module hmb_config_sva (
  // Watched ports
  input wire         i_sys_clk,
  input wire         i_rst,
  input wire         i_set_valid,
  input wire [31:0]  i_cdw11,
  input wire [127:0] i_rd_data,
  input wire         o_rd_req,
  input wire         o_buffer_enable_flag,
  input wire [31:0]  o_cpl_dw0,
  input wire         o_attr_wr,
  input wire [9:0]   o_attr_idx,
  input wire [31:0]  o_attr_data,
  input wire         o_get_done,
  input wire         o_entry_valid,
  input wire [63:0]  o_entry_page_address,
  input wire [31:0]  o_entry_page_count
);
  // Entry fields only, so the reserved top dword cannot leak in
  wire [95:0] ent = i_rd_data[95:0];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_flag;
    i_set_valid |=> {31'h0, o_buffer_enable_flag} == ($past(i_cdw11) & 32'h1);
  endproperty
  a_flag: assert property (p_flag) else $error("enable flag not taken from set");
  property p_noacc; o_rd_req |-> o_buffer_enable_flag; endproperty
  a_noacc: assert property (p_noacc) else $error("read while disabled");
  property p_dw0; o_cpl_dw0[31:2] == 30'h0; endproperty
  a_dw0: assert property (p_dw0) else $error("completion dword upper bits set");
  property p_low; o_attr_wr && o_attr_idx inside {10'h1, 10'h2} |-> o_attr_data[3:0] == 4'h0;
  endproperty
  a_low: assert property (p_low) else $error("address word low bits set");
  property p_rsvd; o_attr_wr && o_attr_idx > 10'h3 |-> o_attr_data == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
  property p_done; o_get_done |-> o_attr_wr && o_attr_idx == 10'h3ff; endproperty
  a_done: assert property (p_done) else $error("done not on last word");
  property p_seq;
    o_attr_wr && o_attr_idx != 10'h3ff |=> o_attr_wr && o_attr_idx == $past(o_attr_idx) + 10'h1;
  endproperty
  a_seq: assert property (p_seq) else $error("attribute words out of order");
  property p_entry;
    o_entry_valid |-> {o_entry_page_count, o_entry_page_address} == $past(ent, 2);
  endproperty
  a_entry: assert property (p_entry) else $error("entry fields wrong");
endmodule // hmb_config_sva

// ==== verif/hmb_host_mem.sv ====
// Host memory model answering descriptor reads
`timescale 1ns/1ns
module hmb_host_mem (
  // Clock and read request
  input  wire         i_sys_clk,
  input  wire         i_req,
  input  wire [63:0]  i_addr,
  input  integer      i_lat,
  // Read answer
  output reg          o_valid,
  output reg  [127:0] o_data
);
  integer    cnt = 0;
  reg [63:0] a = 64'h0;
  initial o_valid = 1'b0;
  initial o_data = 128'h0;
  // Idle data toggles so a stale word never passes for a fresh one
  always @(negedge i_sys_clk) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (cnt == 1) begin
      o_valid <= 1'b1;
      o_data <= {~a[31:0], a[35:4] + 32'h1, a[51:0], 12'h000};
    end
    if (cnt != 0) cnt <= cnt - 1;
    if (i_req) begin
      cnt <= i_lat;
      a <= i_addr;
    end
  end
endmodule // hmb_host_mem

// ==== verif/tb_hmb_config.sv ====
// Self-checking testbench for the host memory buffer configuration block
`timescale 1ns/1ns
module tb_hmb_config;
  reg          i_sys_clk = 1'b0, i_rst = 1'b1, i_set_valid = 1'b0, i_get_valid = 1'b0;
  reg  [31:0]  i_cdw11 = 32'h0, i_cdw12 = 32'h0, i_cdw13 = 32'h0, i_cdw14 = 32'h0;
  reg  [31:0]  i_cdw15 = 32'h0;
  wire         o_get_done, o_attr_wr, o_rd_req, i_rd_valid, o_entry_valid, o_fetch_busy;
  wire         o_fetch_done, o_buffer_enable_flag, o_buffer_return_flag;
  wire [31:0]  o_cpl_dw0, o_attr_data, o_entry_page_count, o_buffer_pages;
  wire [9:0]   o_attr_idx;
  wire [63:0]  o_rd_addr, o_entry_page_address;
  wire [127:0] i_rd_data;
  integer      lat = 1, fail_count = 0, checked = 0, rq = 0, ec = 0, nw, w;
  reg  [63:0]  base = 64'h0, e;
  reg  [31:0]  words [0:3];
  always #5 i_sys_clk = ~i_sys_clk;
  hmb_config hmb_config_inst (.i_sys_clk, .i_rst, .i_set_valid, .i_cdw11, .i_cdw12, .i_cdw13,
    .i_cdw14, .i_cdw15, .i_get_valid, .o_get_done, .o_cpl_dw0, .o_attr_wr, .o_attr_idx,
    .o_attr_data, .o_rd_req, .o_rd_addr, .i_rd_valid, .i_rd_data, .o_entry_valid,
    .o_entry_page_address, .o_entry_page_count, .o_buffer_enable_flag, .o_buffer_return_flag,
    .o_buffer_pages, .o_fetch_busy, .o_fetch_done);
  hmb_host_mem hmb_host_mem_inst (.i_sys_clk, .i_req(o_rd_req), .i_addr(o_rd_addr),
    .i_lat(lat), .o_valid(i_rd_valid), .o_data(i_rd_data));
  task check(input [127:0] seen, input [127:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Reads must walk the list in 16-byte steps and hand back each entry
  always @(negedge i_sys_clk) begin
    if (o_rd_req === 1'b1) begin
      check(o_rd_addr, base + 64'h10 * rq);
      rq = rq + 1;
    end
    if (o_entry_valid === 1'b1) begin
      e = base + 64'h10 * ec;
      check({o_entry_page_count, o_entry_page_address}, {e[35:4] + 32'h1, e[51:0], 12'h0});
      ec = ec + 1;
    end
  end
  task do_set(input [31:0] en, input [31:0] cnt);
    begin
      @(negedge i_sys_clk);
      rq = 0;
      ec = 0;
      i_set_valid = 1'b1;
      i_cdw11 = en;
      i_cdw15 = cnt;
      @(negedge i_sys_clk);
      i_set_valid = 1'b0;
      check(o_buffer_enable_flag, en[0]);
    end
  endtask
  task t_walk(input [31:0] en, input [31:0] cnt, input integer lt, input [31:0] lo, hi);
    begin
      lat = lt;
      i_cdw12 = cnt * 32'h40 + 32'h3;
      i_cdw13 = lo;
      i_cdw14 = hi;
      base = {hi, lo & 32'hfffffff0};
      do_set(en, cnt);
      w = 0;
      while (o_fetch_done !== 1'b1 && w < 500) begin
        @(negedge i_sys_clk);
        w = w + 1;
      end
      check(w < 500, 1'b1);
      @(negedge i_sys_clk);
      check(o_buffer_pages, i_cdw12);
      check(o_buffer_return_flag, en[1]);
      check(rq, cnt);
      check({ec, o_fetch_busy}, {cnt, 1'b0});
    end
  endtask
  task t_query(input [31:0] dw0, input [31:0] cnt);
    begin
      @(negedge i_sys_clk);
      i_get_valid = 1'b1;
      @(negedge i_sys_clk);
      i_get_valid = 1'b0;
      check(o_cpl_dw0, dw0);
      nw = 0;
      w = 0;
      while (o_get_done !== 1'b1 && w < 1100) begin
        @(negedge i_sys_clk);
        w = w + 1;
        if (o_attr_wr === 1'b1) nw = nw + 1;
        if (o_attr_wr === 1'b1 && o_attr_idx < 10'h4) words[o_attr_idx[1:0]] = o_attr_data;
      end
      check(nw, 1024);
      check(words[0], i_cdw12);
      check({words[1], words[2]}, {i_cdw13, i_cdw14} & 64'hfffffff0fffffff0);
      check(words[3], cnt);
    end
  endtask
  // Disable in mid-walk: the pending answer is dropped and no read follows
  task t_abort;
    begin
      lat = 40;
      do_set(32'h1, 32'h5);
      w = 0;
      while (rq == 0 && w < 20) begin
        @(negedge i_sys_clk);
        w = w + 1;
      end
      do_set(32'h0, 32'h5);
      repeat (60) @(negedge i_sys_clk);
      check({rq, ec}, 64'h0);
    end
  endtask
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_rst = 1'b0;
    check({o_cpl_dw0, o_buffer_enable_flag, o_rd_req}, 34'h0);
    t_walk(32'h1, 32'h3, 1, 32'h1234567c, 32'h000000a5);
    t_query(32'h1, 32'h3);
    t_walk(32'h3, 32'h2, 6, 32'h80000008, 32'hfffffff1);
    t_query(32'h3, 32'h2);
    t_walk(32'h1, 32'h0, 1, 32'h0, 32'h0);
    t_query(32'h1, 32'h0);
    t_abort;
    t_query(32'h0, 32'h0);
    report_and_stop;
  end
  // Hang guard, well beyond the few thousand cycles the run needs
  initial begin
    #200000;
    fail_count = fail_count + 1;
    report_and_stop;
  end
endmodule // tb_hmb_config
bind hmb_config hmb_config_sva hmb_config_sva_inst (.i_sys_clk, .i_rst, .i_set_valid, .i_cdw11,
  .i_rd_data, .o_rd_req, .o_buffer_enable_flag, .o_cpl_dw0, .o_attr_wr, .o_attr_idx,
  .o_attr_data, .o_get_done, .o_entry_valid, .o_entry_page_address, .o_entry_page_count);
